// [rbc_pkg.sv]
// Constants, register offsets and types for the receiver back-end configuration port.
package rbc_pkg;
	localparam logic [7:0] ADDR_PORT_CFG     = 8'h00;
	localparam logic [7:0] ADDR_CHAN_INDEX   = 8'h05;
	localparam logic [7:0] ADDR_OUT_TEST     = 8'h0d;
	localparam logic [7:0] ADDR_SELFTEST     = 8'h0e;
	localparam logic [7:0] ADDR_OUT_MODE     = 8'h14;
	localparam logic [7:0] ADDR_SIG_FIRST    = 8'h24;
	localparam logic [7:0] ADDR_SIG_SECOND   = 8'h25;
	localparam logic [7:0] ADDR_NS_CONTROL   = 8'h3c;
	localparam logic [7:0] ADDR_NS_TUNING    = 8'h3e;
	localparam logic [7:0] ADDR_TRANSFER     = 8'hff;
	localparam logic [7:0] ADDR_SHADOW_LO    = 8'h08;
	localparam logic [7:0] ADDR_SHADOW_HI    = 8'h3e;
	localparam logic [7:0] RST_PORT_CFG      = 8'h18;
	localparam logic [7:0] RST_CHAN_INDEX    = 8'h0f;
	localparam logic [7:0] RST_ZERO          = 8'h00;
	localparam int         BIT_LSB_FIRST     = 6;
	localparam int         BIT_PIN_IGNORE    = 4;
	localparam int         BIT_ST_ENABLE     = 0;
	localparam int         BIT_ST_RESTART    = 2;
	localparam int         BIT_PN_LONG_RST   = 5;
	localparam int         BIT_PN_SHORT_RST  = 4;
	localparam int         BIT_TWOS_COMP     = 0;
	localparam logic [2:0] NS_MODE_NARROW    = 3'h0;
	localparam logic [2:0] NS_MODE_WIDE      = 3'h1;
	localparam logic [5:0] TW_NARROW_MAX     = 6'h38;
	localparam logic [5:0] TW_WIDE_MAX       = 6'h21;
	localparam logic [9:0] ST_CYCLES         = 10'h200;
	localparam logic [15:0] PN_SEED          = 16'h7fff;
	localparam logic [15:0] SIG_SEED         = 16'h0000;
	localparam logic [3:0] TEST_OFF          = 4'h0;
	localparam logic [3:0] TEST_MID          = 4'h1;
	localparam logic [3:0] TEST_PN           = 4'h5;
	typedef enum logic [1:0] {RBC_IDLE = 2'b00, RBC_INSTR = 2'b01, RBC_DATA = 2'b11}
		rbc_state_e;
endpackage : rbc_pkg

// [rbc_top.sv]
// Serial configuration port, requantizer controls, self-test and output formatting.
`timescale 1ns/1ns
module rbc_top
	import rbc_pkg::*;
#(
	parameter int SAMPLE_W = 11,
	parameter int CHANNELS = 4
) (
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire logic                chip_select_n,
	input  wire logic                serial_clock,
	input  wire logic                serial_data_in,
	output logic                     serial_data_out,
	output logic                     serial_data_oe_n,
	input  wire logic                requantizer_mode_pin,
	input  wire logic [SAMPLE_W-1:0] sample_a,
	input  wire logic [SAMPLE_W-1:0] sample_b,
	input  wire logic [SAMPLE_W-1:0] sample_c,
	input  wire logic [SAMPLE_W-1:0] sample_d,
	input  wire logic [CHANNELS-1:0] sample_overrange,
	output logic [SAMPLE_W-1:0]      data_out,
	output logic                     data_clock_out,
	output logic [CHANNELS-1:0]      requantizer_enable,
	output logic [CHANNELS-1:0]      requantizer_wide,
	output logic [CHANNELS*6-1:0]    band_tuning_word,
	output logic                     selftest_busy
);
	// Fibonacci step shared by generator and signature.
	function automatic logic [15:0] lfsr_step(input logic [15:0] v, input logic [15:0] d);
		lfsr_step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]} ^ d;
	endfunction : lfsr_step

	function automatic logic [7:0] bit_rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			bit_rev[i] = v[7-i];
		end
	endfunction : bit_rev

	// Two-stage synchronisers for pins.
	logic [1:0] cs_sync, sck_sync, sdi_sync, mode_sync;
	logic       sck_last, cs_last;
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cs_sync   <= 2'b11;
			sck_sync  <= 2'b00;
			sdi_sync  <= 2'b00;
			mode_sync <= 2'b11;
			sck_last  <= 1'b0;
			cs_last   <= 1'b1;
		end else begin
			cs_sync   <= {cs_sync[0], chip_select_n};
			sck_sync  <= {sck_sync[0], serial_clock};
			sdi_sync  <= {sdi_sync[0], serial_data_in};
			mode_sync <= {mode_sync[0], requantizer_mode_pin};
			sck_last  <= sck_sync[1];
			cs_last   <= cs_sync[1];
		end
	end
	wire cs_act   = !cs_sync[1];
	wire sck_rise = cs_act && sck_sync[1] && !sck_last;
	wire sck_fall = cs_act && !sck_sync[1] && sck_last;
	wire cs_fall  = cs_last && !cs_sync[1];

	// Serial frame state.
	rbc_state_e  state, next_state;
	logic [15:0] shift, next_shift;
	logic [4:0]  bitcnt, next_bitcnt;
	logic        is_read, next_is_read;
	logic [1:0]  len, next_len;
	logic [7:0]  addr, next_addr;
	logic [1:0]  bytes_done, next_bytes_done;
	logic [7:0]  tx, next_tx;
	logic        sdo, next_sdo, oe_n, next_oe_n;
	logic        wr_pulse, next_wr_pulse;
	logic [7:0]  wr_addr, next_wr_addr, wr_data, next_wr_data;
	// Register state: live copies and shadow copies.
	logic [7:0] port_cfg, chan_index, out_test, out_mode, st_ctrl;
	logic [7:0] sh_out_test, sh_out_mode, sh_st_ctrl;
	logic [7:0] ns_ctrl [CHANNELS], ns_tune [CHANNELS];
	logic [7:0] sh_ns_ctrl [CHANNELS], sh_ns_tune [CHANNELS];
	logic [15:0] signature;
	logic [7:0] rd_data;
	logic       st_done;
	wire lsb_first = port_cfg[BIT_LSB_FIRST];
	logic [1:0] first_ch;

	always_comb begin
		first_ch = 2'd0;
		for (int c = CHANNELS - 1; c >= 0; c--) begin
			if (chan_index[c]) first_ch = 2'(c);
		end
		case (addr)
			ADDR_PORT_CFG:   rd_data = port_cfg;
			ADDR_CHAN_INDEX: rd_data = chan_index;
			ADDR_OUT_TEST:   rd_data = sh_out_test;
			ADDR_OUT_MODE:   rd_data = sh_out_mode;
			ADDR_SELFTEST:   rd_data = sh_st_ctrl;
			ADDR_SIG_FIRST:  rd_data = signature[7:0];
			ADDR_SIG_SECOND: rd_data = signature[15:8];
			ADDR_NS_CONTROL: rd_data = sh_ns_ctrl[first_ch];
			ADDR_NS_TUNING:  rd_data = sh_ns_tune[first_ch];
			default:         rd_data = RST_ZERO;
		endcase
	end

	always_comb begin
		next_state      = state;
		next_shift      = shift;
		next_bitcnt     = bitcnt;
		next_is_read    = is_read;
		next_len        = len;
		next_addr       = addr;
		next_bytes_done = bytes_done;
		next_tx         = tx;
		next_sdo        = sdo;
		next_oe_n       = oe_n;
		next_wr_pulse   = 1'b0;
		next_wr_addr    = wr_addr;
		next_wr_data    = wr_data;
		if (!cs_act) begin
			// Select high pauses a frame at a byte boundary of the data phase and aborts it mid-byte or inside the instruction; the pin is released.
			next_oe_n = 1'b1;
			if (state == RBC_INSTR || bitcnt != 5'd0) next_state = RBC_IDLE;
		end else if (cs_fall && state == RBC_IDLE) begin
			next_state  = RBC_INSTR;
			next_bitcnt = 5'd0;
		end else if (sck_rise && state == RBC_INSTR) begin
			next_shift  = {shift[14:0], sdi_sync[1]};
			next_bitcnt = bitcnt + 5'd1;
			if (bitcnt == 5'd15) begin
				// Instruction: read flag, two length bits, then address.
				next_is_read    = lsb_first ? sdi_sync[1] : shift[14];
				next_len        = lsb_first ? {shift[0], shift[1]} : shift[13:12];
				next_addr       = lsb_first ? bit_rev(shift[14:7])
				                            : {shift[6:0], sdi_sync[1]};
				next_bytes_done = 2'd0;
				next_bitcnt     = 5'd0;
				next_state      = RBC_DATA;
			end
		end else if (sck_rise && state == RBC_DATA) begin
			next_shift  = {shift[14:0], sdi_sync[1]};
			next_bitcnt = bitcnt + 5'd1;
			if (bitcnt == 5'd7) begin
				next_bitcnt = 5'd0;
				if (!is_read) begin
					next_wr_pulse = 1'b1;
					next_wr_addr  = addr;
					next_wr_data  = lsb_first ? bit_rev({shift[6:0], sdi_sync[1]})
					                          : {shift[6:0], sdi_sync[1]};
				end
				next_addr = lsb_first ? addr + 8'd1 : addr - 8'd1;
				if (len != 2'd3 && bytes_done == len) next_state = RBC_IDLE;
				else next_bytes_done = bytes_done + 2'd1;
			end
		end else if (sck_fall && state == RBC_DATA && is_read) begin
			// Drive the next read bit on the falling edge for the host's rising sample.
			next_oe_n = 1'b0;
			if (bitcnt == 5'd0) begin
				next_tx  = lsb_first ? {1'b0, rd_data[7:1]} : {rd_data[6:0], 1'b0};
				next_sdo = lsb_first ? rd_data[0] : rd_data[7];
			end else begin
				next_tx  = lsb_first ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
				next_sdo = lsb_first ? tx[0] : tx[7];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state <= RBC_IDLE; shift <= 16'h0000; bitcnt <= 5'd0; is_read <= 1'b0;
			len <= 2'd0; addr <= 8'h00; bytes_done <= 2'd0; tx <= 8'h00;
			sdo <= 1'b0; oe_n <= 1'b1; wr_pulse <= 1'b0; wr_addr <= 8'h00; wr_data <= 8'h00;
		end else begin
			state <= next_state; shift <= next_shift; bitcnt <= next_bitcnt;
			is_read <= next_is_read; len <= next_len; addr <= next_addr;
			bytes_done <= next_bytes_done; tx <= next_tx; sdo <= next_sdo;
			oe_n <= next_oe_n; wr_pulse <= next_wr_pulse; wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
		end
	end
	assign serial_data_out  = sdo;
	assign serial_data_oe_n = oe_n;

	// Register writes; shadowed locations go live on the transfer command.
	wire do_xfer = wr_pulse && wr_addr == ADDR_TRANSFER && wr_data[0];
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			port_cfg <= RST_PORT_CFG; chan_index <= RST_CHAN_INDEX;
			out_test <= RST_ZERO; out_mode <= RST_ZERO; st_ctrl <= RST_ZERO;
			sh_out_test <= RST_ZERO; sh_out_mode <= RST_ZERO; sh_st_ctrl <= RST_ZERO;
			for (int c = 0; c < CHANNELS; c++) begin
				ns_ctrl[c] <= RST_ZERO; ns_tune[c] <= RST_ZERO;
				sh_ns_ctrl[c] <= RST_ZERO; sh_ns_tune[c] <= RST_ZERO;
			end
		end else begin
			if (wr_pulse) begin
				case (wr_addr)
					ADDR_PORT_CFG:   port_cfg <= {1'b0, wr_data[6] | wr_data[1], 3'b011, 1'b0,
					                              wr_data[6] | wr_data[1], 1'b0};
					ADDR_CHAN_INDEX: chan_index <= {4'h0, wr_data[3:0]};
					ADDR_OUT_TEST:   sh_out_test <= wr_data;
					ADDR_OUT_MODE:   sh_out_mode <= wr_data;
					ADDR_SELFTEST:   sh_st_ctrl <= wr_data;
					default: ;
				endcase
				for (int c = 0; c < CHANNELS; c++) begin
					if (chan_index[c] && wr_addr == ADDR_NS_CONTROL) sh_ns_ctrl[c] <= wr_data;
					if (chan_index[c] && wr_addr == ADDR_NS_TUNING)  sh_ns_tune[c] <= wr_data;
				end
			end
			if (do_xfer) begin
				out_test <= sh_out_test; out_mode <= sh_out_mode; st_ctrl <= sh_st_ctrl;
				for (int c = 0; c < CHANNELS; c++) begin
					ns_ctrl[c] <= sh_ns_ctrl[c]; ns_tune[c] <= sh_ns_tune[c];
				end
			end else if (st_done) begin
				st_ctrl[BIT_ST_ENABLE] <= 1'b0;
			end
			// A finished run drops the shadow start bit too, so a later transfer cannot relaunch it.
			if (st_done && !(wr_pulse && wr_addr == ADDR_SELFTEST))
				sh_st_ctrl[BIT_ST_ENABLE] <= 1'b0;
		end
	end

	// Requantizer control per channel.
	logic [CHANNELS-1:0]   next_rq_en, next_rq_wide;
	logic [CHANNELS*6-1:0] next_tw;
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			// Ignore bit hands control to the register; otherwise the pin rules.
			next_rq_en[c] = ns_ctrl[c][BIT_PIN_IGNORE] ? 1'b1 : !mode_sync[1];
			next_rq_wide[c] = ns_ctrl[c][3:1] == NS_MODE_WIDE;
			if (ns_ctrl[c][3:1] != NS_MODE_NARROW && ns_ctrl[c][3:1] != NS_MODE_WIDE)
				next_rq_en[c] = 1'b0;
			// Unsupported tuning words are clamped to the last valid step.
			if (next_rq_wide[c])
				next_tw[c*6 +: 6] = ns_tune[c][5:0] > TW_WIDE_MAX ? TW_WIDE_MAX
				                  : ns_tune[c][5:0];
			else
				next_tw[c*6 +: 6] = ns_tune[c][5:0] > TW_NARROW_MAX ? TW_NARROW_MAX
				                  : ns_tune[c][5:0];
		end
	end

	// Self-test and pattern generators.
	logic [15:0] pn, next_pn, next_sig;
	logic [9:0]  st_cnt, next_st_cnt;
	logic        st_run, next_st_run, st_en_last;
	wire st_start = st_ctrl[BIT_ST_ENABLE] && !st_en_last && !st_run;
	always_comb begin
		next_pn     = lfsr_step(pn, 16'h0000);
		next_sig    = signature;
		next_st_cnt = st_cnt;
		next_st_run = st_run;
		st_done     = 1'b0;
		if (out_test[BIT_PN_LONG_RST] || out_test[BIT_PN_SHORT_RST]) next_pn = PN_SEED;
		if (st_start) begin
			next_st_run = 1'b1;
			next_st_cnt = 10'd0;
			next_sig    = SIG_SEED;
			if (st_ctrl[BIT_ST_RESTART]) next_pn = PN_SEED;
		end else if (st_run) begin
			next_sig    = lfsr_step(signature, {5'h00, pn[10:0]});
			next_st_cnt = st_cnt + 10'd1;
			if (st_cnt == ST_CYCLES - 10'd1) begin
				next_st_run = 1'b0;
				st_done     = 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pn <= PN_SEED; signature <= SIG_SEED; st_cnt <= 10'd0;
			st_run <= 1'b0; st_en_last <= 1'b0; selftest_busy <= 1'b0;
		end else begin
			pn <= next_pn; signature <= next_sig; st_cnt <= next_st_cnt;
			st_run <= next_st_run; st_en_last <= st_ctrl[BIT_ST_ENABLE];
			selftest_busy <= next_st_run;
		end
	end

	// Output formatting: A,C on high phase, B,D on low phase.
	logic [1:0]          phase;
	logic [SAMPLE_W-1:0] next_data, raw;
	logic                ovr;
	always_comb begin
		case (phase)
			2'd0: begin raw = sample_a; ovr = sample_overrange[0]; end
			2'd1: begin raw = sample_b; ovr = sample_overrange[1]; end
			2'd2: begin raw = sample_c; ovr = sample_overrange[2]; end
			default: begin raw = sample_d; ovr = sample_overrange[3]; end
		endcase
		if (ovr) raw = raw[SAMPLE_W-1] ? '1 : '0;
		if (out_test[3:0] == TEST_MID) raw = {1'b1, {(SAMPLE_W-1){1'b0}}};
		else if (out_test[3:0] == TEST_PN || st_run) raw = pn[SAMPLE_W-1:0];
		next_data = out_mode[BIT_TWOS_COMP] ? {~raw[SAMPLE_W-1], raw[SAMPLE_W-2:0]} : raw;
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			phase <= 2'd0; data_out <= '0; data_clock_out <= 1'b0;
			requantizer_enable <= '0; requantizer_wide <= '0; band_tuning_word <= '0;
		end else begin
			phase <= phase + 2'd1;
			data_out <= next_data;
			data_clock_out <= !phase[0];
			requantizer_enable <= next_rq_en; requantizer_wide <= next_rq_wide;
			band_tuning_word <= next_tw;
		end
	end

	property p_selftest_len;
		@(posedge ref_clk) disable iff (!reset_n) $rose(st_run) |-> st_run [*8];
	endproperty
	a_selftest_len: assert property (p_selftest_len) else $error("self-test ended early");
	property p_oe_release;
		@(posedge ref_clk) disable iff (!reset_n) !cs_act |=> serial_data_oe_n;
	endproperty
	a_oe_release: assert property (p_oe_release) else $error("data pin driven while idle");
	property p_dco;
		@(posedge ref_clk) disable iff (!reset_n) phase[0] |=> !data_clock_out;
	endproperty
	a_dco: assert property (p_dco) else $error("data clock phase wrong");
	property p_tw_narrow;
		@(posedge ref_clk) disable iff (!reset_n) band_tuning_word[5:0] <= TW_NARROW_MAX;
	endproperty
	a_tw_narrow: assert property (p_tw_narrow) else $error("tuning word out of range");
	property p_wide;
		@(posedge ref_clk) disable iff (!reset_n)
			ns_ctrl[0][3:1] == NS_MODE_WIDE |=> requantizer_wide[0];
	endproperty
	a_wide: assert property (p_wide) else $error("wide mode missed");
	property p_pin;
		@(posedge ref_clk) disable iff (!reset_n)
			!ns_ctrl[0][BIT_PIN_IGNORE] && mode_sync[1] |=> !requantizer_enable[0];
	endproperty
	a_pin: assert property (p_pin) else $error("mode pin ignored");
	property p_ignore;
		@(posedge ref_clk) disable iff (!reset_n)
			ns_ctrl[0][BIT_PIN_IGNORE] && ns_ctrl[0][3:1] == NS_MODE_NARROW
			|=> requantizer_enable[0];
	endproperty
	a_ignore: assert property (p_ignore) else $error("pin override lost");
	property p_seed;
		@(posedge ref_clk) disable iff (!reset_n)
			out_test[BIT_PN_LONG_RST] && !st_start |=> pn == PN_SEED;
	endproperty
	a_seed: assert property (p_seed) else $error("generator not held");
endmodule : rbc_top

// [rbc_host.sv]
// Serial host model that frames instructions and data bytes on the configuration port.
`timescale 1ns/1ns
module rbc_host (
	input  wire logic ref_clk,
	output logic      chip_select_n,
	output logic      serial_clock,
	output logic      serial_data_in,
	input  wire logic serial_data_out,
	input  wire logic serial_data_oe_n
);
	logic host_drive;
	logic host_bit;
	logic float_pat;
	logic lsb_mode;

	initial begin
		chip_select_n = 1'b1;
		serial_clock  = 1'b0;
		host_drive    = 1'b0;
		host_bit      = 1'b0;
		float_pat     = 1'b0;
		lsb_mode      = 1'b0;
	end

	// An undriven pin shows a changing pattern so that a stale level never passes as data.
	always @(posedge ref_clk) begin
		float_pat <= !float_pat;
	end

	assign serial_data_in = !serial_data_oe_n ? serial_data_out : (host_drive ? host_bit : float_pat);

	// Half periods of 62 and 63 ns make the 125 ns serial clock; the device resynchronises it.
	task automatic pulse(output logic smp);
		#62 serial_clock = 1'b1;
		smp = serial_data_in;
		#63 serial_clock = 1'b0;
	endtask : pulse

	task automatic xfer(input logic rd, input logic [1:0] len, input logic [7:0] addr,
		input logic [23:0] wdata, input logic stall, output logic [23:0] rdata);
		logic [15:0] instr;
		logic        smp;
		int          j;
		instr = {rd, len, 5'h00, addr};
		rdata = 24'h0;
		@(negedge ref_clk);
		#1 chip_select_n = 1'b0;
		host_drive = 1'b1;
		for (int i = 15; i >= 0; i--) begin
			host_bit = lsb_mode ? instr[15-i] : instr[i];
			pulse(smp);
		end
		host_drive = !rd;
		for (int b = 0; b <= int'(len); b++) begin
			for (int i = 7; i >= 0; i--) begin
				j = 16 - 8 * b + (lsb_mode ? 7 - i : i);
				host_bit = wdata[j];
				pulse(smp);
				rdata[j] = smp;
			end
			if (stall && b < int'(len)) begin
				#62 chip_select_n = 1'b1;
				#188 chip_select_n = 1'b0;
			end
		end
		#62 chip_select_n = 1'b1;
		host_drive = 1'b0;
		#63;
		// Returning on a falling edge keeps the bench's next stimulus off the sampling edge.
		@(negedge ref_clk);
	endtask : xfer
endmodule : rbc_host

// [receiver_backend_config_port_tb.sv]
// Self-checking testbench for the receiver back-end configuration port.
`timescale 1ns/1ns
module receiver_backend_config_port_tb
	import rbc_pkg::*;
;
	logic        ref_clk;
	logic        reset_n;
	logic        chip_select_n;
	logic        serial_clock;
	logic        serial_data_in;
	logic        serial_data_out;
	logic        serial_data_oe_n;
	logic        mode_pin;
	logic [10:0] smp_ac;
	logic [10:0] smp_bd;
	logic [3:0]  ovr;
	logic [10:0] data_out;
	logic        data_clock_out;
	logic [3:0]  rq_en;
	logic [3:0]  rq_wide;
	logic [23:0] tw;
	logic        busy;
	logic [23:0] rdat;
	logic [15:0] sig_a;
	logic [15:0] sig_b;
	int          fails;
	int          num_checks;
	int          busy_cnt;

	always #2 ref_clk = !ref_clk;

	always @(posedge ref_clk) begin
		if (busy === 1'b1) begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	rbc_top DUT (
		.ref_clk              (ref_clk),
		.reset_n              (reset_n),
		.chip_select_n        (chip_select_n),
		.serial_clock         (serial_clock),
		.serial_data_in       (serial_data_in),
		.serial_data_out      (serial_data_out),
		.serial_data_oe_n     (serial_data_oe_n),
		.requantizer_mode_pin (mode_pin),
		.sample_a             (smp_ac),
		.sample_b             (smp_bd),
		.sample_c             (smp_ac),
		.sample_d             (smp_bd),
		.sample_overrange     (ovr),
		.data_out             (data_out),
		.data_clock_out       (data_clock_out),
		.requantizer_enable   (rq_en),
		.requantizer_wide     (rq_wide),
		.band_tuning_word     (tw),
		.selftest_busy        (busy)
	);

	rbc_host host (
		.ref_clk          (ref_clk),
		.chip_select_n    (chip_select_n),
		.serial_clock     (serial_clock),
		.serial_data_in   (serial_data_in),
		.serial_data_out  (serial_data_out),
		.serial_data_oe_n (serial_data_oe_n)
	);

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (8) @(negedge ref_clk);
	endtask : settle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b0, 2'd0, a, {d, 16'h0}, 1'b0, rdat);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host.xfer(1'b1, 2'd0, a, 24'h0, 1'b0, rdat);
		chk({16'h0, rdat[23:16]}, {16'h0, e});
	endtask : rd

	// Walks four sample slots and checks the lane shown in each clock phase.
	task automatic fmt(input logic [10:0] hi, input logic [10:0] lo);
		logic prev;
		settle();
		prev = data_clock_out;
		for (int i = 0; i < 4; i++) begin
			@(negedge ref_clk);
			chk({23'h0, data_clock_out}, {23'h0, !prev});
			chk({13'h0, data_out}, {13'h0, data_clock_out ? hi : lo});
			prev = data_clock_out;
		end
	endtask : fmt

	task automatic builtin_self_test(output logic [15:0] sig);
		logic [10:0] first;
		logic        moved;
		int          n;
		wr(ADDR_SELFTEST, 8'h05);
		busy_cnt = 0;
		wr(ADDR_TRANSFER, 8'h01);
		n = 0;
		while (busy !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		first = data_out;
		moved = 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(negedge ref_clk);
			if (data_out !== first) moved = 1'b1;
			n++;
		end
		chk({23'h0, moved}, 24'h1);
		chk(busy_cnt[23:0], {14'h0, ST_CYCLES});
		host.xfer(1'b1, 2'd1, ADDR_SIG_SECOND, 24'h0, 1'b0, rdat);
		sig = rdat[23:8];
		rd(ADDR_SELFTEST, 8'h04);
	endtask : builtin_self_test

	initial begin
		#300000;
		fails++;
		$display("Error at %0t: watchdog expired", $time);
		close_out();
	end

	initial begin
		ref_clk    = 1'b0;
		reset_n    = 1'b0;
		mode_pin   = 1'b1;
		smp_ac     = 11'h123;
		smp_bd     = 11'h7ff;
		ovr        = 4'h0;
		fails      = 0;
		num_checks = 0;
		busy_cnt   = 0;
		repeat (4) @(negedge ref_clk);
		reset_n = 1'b1;
		settle();
		chk({23'h0, serial_data_oe_n}, 24'h1);
		rd(ADDR_PORT_CFG, RST_PORT_CFG);
		rd(ADDR_CHAN_INDEX, RST_CHAN_INDEX);
		rd(8'h13, 8'h00);
		wr(ADDR_PORT_CFG, 8'h42);
		host.lsb_mode = 1'b1;
		rd(ADDR_PORT_CFG, 8'h5a);
		rd(ADDR_CHAN_INDEX, RST_CHAN_INDEX);
		wr(ADDR_PORT_CFG, 8'h18);
		host.lsb_mode = 1'b0;
		rd(ADDR_PORT_CFG, RST_PORT_CFG);
		$display("test reset done");
		wr(ADDR_CHAN_INDEX, 8'h01);
		wr(ADDR_NS_CONTROL, 8'h11);
		wr(ADDR_NS_TUNING, {2'b00, TW_NARROW_MAX});
		settle();
		chk(tw, 24'h0);
		wr(ADDR_TRANSFER, 8'h01);
		settle();
		chk({18'h0, tw[5:0]}, {18'h0, TW_NARROW_MAX});
		chk({22'h0, rq_en[0], rq_wide[0]}, 24'h2);
		rd(ADDR_TRANSFER, 8'h00);
		$display("test narrow done");
		wr(ADDR_CHAN_INDEX, 8'h02);
		host.xfer(1'b0, 2'd2, ADDR_NS_TUNING, 24'h3f0013, 1'b1, rdat);
		wr(ADDR_TRANSFER, 8'h01);
		settle();
		chk({18'h0, tw[11:6]}, {18'h0, TW_WIDE_MAX});
		chk({22'h0, rq_en[1], rq_wide[1]}, 24'h3);
		rd(ADDR_NS_CONTROL, 8'h13);
		$display("test wide done");
		chk({22'h0, rq_en[3:2]}, 24'h0);
		mode_pin = 1'b0;
		settle();
		chk({20'h0, rq_en}, 24'hf);
		mode_pin = 1'b1;
		settle();
		chk({20'h0, rq_en}, 24'h3);
		wr(ADDR_CHAN_INDEX, 8'h03);
		rd(ADDR_NS_TUNING, {2'b00, TW_NARROW_MAX});
		$display("test mode pin done");
		fmt(11'h123, 11'h7ff);
		wr(ADDR_OUT_TEST, {4'h0, TEST_MID});
		wr(ADDR_TRANSFER, 8'h01);
		fmt(11'h400, 11'h400);
		wr(ADDR_OUT_TEST, 8'h35);
		wr(ADDR_TRANSFER, 8'h01);
		settle();
		fmt(PN_SEED[10:0], PN_SEED[10:0]);
		wr(ADDR_OUT_TEST, 8'h00);
		wr(ADDR_OUT_MODE, 8'h01);
		wr(ADDR_TRANSFER, 8'h01);
		fmt(11'h523, 11'h3ff);
		ovr = 4'hf;
		fmt(11'h400, 11'h3ff);
		ovr = 4'h0;
		$display("test format done");
		builtin_self_test(sig_a);
		builtin_self_test(sig_b);
		chk({8'h0, sig_b}, {8'h0, sig_a});
		$display("test self-test done");
		close_out();
	end
endmodule : receiver_backend_config_port_tb
